// ### src/tsm_switch_cfg.sv
// switching matrix configuration register and the serial logic it steers
// assumes an AXI4-Lite master and link pins foreign to REF_CLK
//
// Summary of operation
// - drive_mode_a set: lines 0-3,6-7 push-pull; cleared: open drain.
// - drive_mode_b makes the same choice for output lines 4 and 5.
// - generator sends prbs in its slot when enabled, else reset and zeros.
// - analyzer runs while enabled, held in reset otherwise.
// - corrupt bit rising inverts exactly one transmitted prbs bit.
// - corrupt bit self-clears once the corrupted bit is sent.
// - message mode outputs connection memory contents on all lines.
// - otherwise each connection entry selects the input line its output copies.
// - alarm detection runs sixteen detectors only while enabled.
// - both B channels all ones for 30 ms declares an alarm.
// - an alarm stores a status entry; ALARM_CH signals only the lowest channel firing.
// - double rate on mux 0 runs line 0 at 4Mb/s, ignores line 1.
// - same for mux 2, ignoring lines 3.
// - same for mux 4, ignoring lines 5; no GCI on muxes 4/5.
// - same for mux 6; HDLC then uses input 8 and the tx pin.
// - rate select 00 gives 2048 kbit/s, 01 gives 1536 kbit/s.
// - half rate switch a takes 64 channels on line 0 at 2048.
// - then input 2 carries mux 0 delayed four bit-times.
// - then output 2 is internal only.
// - half rate switch b does the same for line 1.
// - then lines 3 internal; input 3 is mux 1 delayed four bits.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tsm_consts.svh"
module tsm_switch_cfg
   import tsm_pkg::*;
#(
   parameter int ALARM_CYC = `TSM_ALARM_CYC
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic MUX_BIT_CLOCK,
   input wire logic FRAME_SYNC,
   input wire logic [7:0] DIN,
   output logic [7:0] DOUT_O,
   output logic [7:0] DOUT_OE,
   output logic ALARM_EVT,
   output logic [3:0] ALARM_CH,
   output logic HDLC_DIRECT
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] lfsr_step(input logic [8:0] l,
                                            input logic b);
      lfsr_step = {l[7:0], b};
   endfunction : lfsr_step
   function automatic logic [7:0] reg_idx(input logic [31:0] a);
      reg_idx = a[9:2];
   endfunction : reg_idx

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   tsm_cfg_s cfg_ff;
   tsm_prbs_s prbs_ff;
   logic [7:0] conn_ff [8];
   logic [15:0] alarm_sts_ff;
   logic [15:0] err_cnt_ff;
   logic [7:0] aw_idx_ff, ar_idx_ff;
   logic aw_got_ff, w_got_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic [2:0] clk_sync_ff, fs_sync_ff;
   logic [7:0] din_s1_ff, din_s2_ff;
   logic [8:0] edge_cnt_ff;
   logic [8:0] gen_lfsr_ff, chk_lfsr_ff;
   logic [3:0] dly0_ff, dly1_ff;
   logic [7:0] tx_ff;
   logic [19:0] alarm_tmr_ff [16];
   logic [15:0] alarm_done_ff;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire wr_go = aw_got_ff && w_got_ff && !S_AXI_BVALID;
   wire wr_cfg = wr_go && aw_idx_ff == `TSM_IDX_CFG;
   wire wr_conn = wr_go && aw_idx_ff == `TSM_IDX_CONN;
   wire wr_prbs = wr_go && aw_idx_ff == `TSM_IDX_PRBS;
   wire wr_alarm = wr_go && aw_idx_ff == `TSM_IDX_ALARM;
   wire wr_ok = wr_cfg || wr_conn || wr_prbs || wr_alarm
      || aw_idx_ff == `TSM_IDX_ERRS;
   wire [15:0] wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   wire [15:0] cfg_w = (wdata_ff[15:0] & wmask)
      | (16'(cfg_ff) & ~wmask);
   wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
   wire [7:0] ri = reg_idx(S_AXI_ARADDR);
   wire rd_ok = ri == `TSM_IDX_CFG || ri == `TSM_IDX_CONN
      || ri == `TSM_IDX_PRBS || ri == `TSM_IDX_ALARM
      || ri == `TSM_IDX_ERRS;
   // connection register reads back entry 0 only
   wire [31:0] rd_val = ri == `TSM_IDX_CFG ? {16'h0000, 16'(cfg_ff)} :
      ri == `TSM_IDX_CONN ? {24'h000000, conn_ff[0]} :
      ri == `TSM_IDX_PRBS ? {23'h000000, 9'(prbs_ff)} :
      ri == `TSM_IDX_ALARM ? {16'h0000, alarm_sts_ff} :
      ri == `TSM_IDX_ERRS ? {16'h0000, err_cnt_ff} : 32'h00000000;

   // ------------------------------------------------------------
   // link timing
   // ------------------------------------------------------------
   wire edge_s = clk_sync_ff[1] && !clk_sync_ff[2];
   wire fs_s = fs_sync_ff[1];
   wire [1:0] rate = {cfg_ff.rate_select_hi, cfg_ff.rate_select_lo};
   wire base_rate = rate == 2'b00;
   wire [3:0] dr = {cfg_ff.double_rate_mux6, cfg_ff.double_rate_mux4,
      cfg_ff.double_rate_mux2, cfg_ff.double_rate_mux0};
   // doubling only exists at 2048 kbit/s
   wire [3:0] dbl = dr & {4{base_rate}};
   wire sw0_on = cfg_ff.half_rate_switch_a && base_rate && !dbl[0];
   wire sw1_on = cfg_ff.half_rate_switch_b && base_rate && !dbl[0];
   wire [7:0] fast = {dbl[3], dbl[3], dbl[2], dbl[2],
      dbl[1], dbl[1], dbl[0], dbl[0]};
   // the link clock is the double clock: a slow bit is two edges
   wire [7:0] strobe = {8{edge_s}} & (fast | {8{edge_cnt_ff[0]}});
   wire [8:0] bix_slow = {1'b0, edge_cnt_ff[8:1]};
   wire [8:0] bix_fast = edge_cnt_ff;
   wire [7:0] lost = {dbl[3], 1'b0, dbl[2], 1'b0,
      dbl[1] | sw1_on, sw0_on, dbl[0], 1'b0};
   // inputs 2 and 3 are replaced by delayed copies of 0 and 1
   wire [7:0] din_eff = {din_s2_ff[7:4],
      sw1_on ? dly1_ff[3] : din_s2_ff[3],
      sw0_on ? dly0_ff[3] : din_s2_ff[2],
      din_s2_ff[1:0]};

   // ------------------------------------------------------------
   // prbs generator and analyzer
   // ------------------------------------------------------------
   wire [8:0] pb = fast[prbs_ff.line] ? bix_fast : bix_slow;
   wire prbs_hit = strobe[prbs_ff.line] && pb[8:3] == prbs_ff.slot;
   wire gen_fb = gen_lfsr_ff[8] ^ gen_lfsr_ff[4];
   wire corrupt_now = prbs_hit && cfg_ff.prbs_gen_enable
      && cfg_ff.prbs_gen_corrupt;
   wire gen_bit = cfg_ff.prbs_gen_enable ? gen_fb ^ corrupt_now : 1'b0;
   wire chk_in = din_eff[prbs_ff.line];
   wire chk_bad = chk_in != (chk_lfsr_ff[8] ^ chk_lfsr_ff[4]);
   wire sgc_set = wr_cfg && cfg_w[`TSM_POS_CORRUPT];
   wire nxt_corrupt = sgc_set ? 1'b1 :
      corrupt_now ? 1'b0 : cfg_ff.prbs_gen_corrupt;

   // ------------------------------------------------------------
   // transmit bit per line
   // ------------------------------------------------------------
   logic [7:0] nxt_tx, nxt_o, nxt_oe;
   always_comb begin
      nxt_tx = tx_ff;
      nxt_o = 8'h00;
      nxt_oe = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (strobe[i]) begin
            if (cfg_ff.message_mode)
               nxt_tx[i] = conn_ff[i][3'(7 - (fast[i] ? bix_fast[2:0]
                  : bix_slow[2:0]))];
            else if (prbs_hit && prbs_ff.line == 3'(i))
               nxt_tx[i] = gen_bit;
            else
               nxt_tx[i] = din_eff[conn_ff[i][2:0]];
         end
         if (i == 4 || i == 5) begin
            nxt_o[i] = cfg_ff.drive_mode_b & tx_ff[i];
            nxt_oe[i] = !lost[i] && (cfg_ff.drive_mode_b || !tx_ff[i]);
         end else begin
            nxt_o[i] = cfg_ff.drive_mode_a & tx_ff[i];
            nxt_oe[i] = !lost[i] && (cfg_ff.drive_mode_a || !tx_ff[i]);
         end
      end
   end

   // ------------------------------------------------------------
   // alarm detectors: GCI lines 4 and 5, B1/B2 are slots 4k, 4k+1
   // ------------------------------------------------------------
   wire alarm_on = cfg_ff.alarm_detect_enable && !dbl[2];
   logic [15:0] b_zero, fire, nxt_sts;
   logic [3:0] fire_ch;
   always_comb begin
      b_zero = 16'h0000;
      fire = 16'h0000;
      fire_ch = 4'h0;
      for (int c = 0; c < 16; c++) begin
         if (strobe[4 + c / 8] && bix_slow[7:5] == 3'(c % 8)
            && !bix_slow[4] && !din_eff[4 + c / 8])
            b_zero[c] = 1'b1;
         fire[c] = alarm_on && !alarm_done_ff[c] && !b_zero[c]
            && alarm_tmr_ff[c] == 20'(ALARM_CYC - 1);
      end
      for (int c = 15; c >= 0; c--)
         if (fire[c])
            fire_ch = 4'(c);
      // new alarms win over a write-one-to-clear
      nxt_sts = (wr_alarm ? alarm_sts_ff & ~wdata_ff[15:0]
         : alarm_sts_ff) | fire;
   end

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `TSM_RESP_OK;
         aw_idx_ff <= 8'h00;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
      end else begin
         S_AXI_AWREADY <= !aw_got_ff && !S_AXI_AWREADY;
         S_AXI_WREADY <= !w_got_ff && !S_AXI_WREADY;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_ff <= 1'b1;
            aw_idx_ff <= reg_idx(S_AXI_AWADDR);
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? `TSM_RESP_OK : `TSM_RESP_ERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `TSM_RESP_OK;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !rd_go;
         if (rd_go) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? `TSM_RESP_OK : `TSM_RESP_ERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration state
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         cfg_ff <= tsm_cfg_s'(`TSM_CFG_RST);
         prbs_ff <= tsm_prbs_s'(9'h000);
         for (int i = 0; i < 8; i++)
            conn_ff[i] <= 8'h00;
         alarm_sts_ff <= 16'h0000;
         HDLC_DIRECT <= 1'b0;
      end else begin
         if (wr_cfg)
            cfg_ff <= tsm_cfg_s'(cfg_w);
         cfg_ff.prbs_gen_corrupt <= nxt_corrupt;
         if (wr_prbs)
            prbs_ff <= tsm_prbs_s'(wdata_ff[8:0]);
         if (wr_conn)
            conn_ff[wdata_ff[`TSM_CONN_ENTRY_HI:`TSM_CONN_ENTRY_LO]]
               <= wdata_ff[7:0];
         alarm_sts_ff <= nxt_sts;
         HDLC_DIRECT <= dbl[3];
      end
   end

   // ------------------------------------------------------------
   // link side
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         clk_sync_ff <= 3'h0;
         fs_sync_ff <= 3'h0;
         din_s1_ff <= 8'h00;
         din_s2_ff <= 8'h00;
         edge_cnt_ff <= 9'h000;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], MUX_BIT_CLOCK};
         fs_sync_ff <= {fs_sync_ff[1:0], FRAME_SYNC};
         din_s1_ff <= DIN;
         din_s2_ff <= din_s1_ff;
         if (edge_s)
            edge_cnt_ff <= fs_s ? 9'h000 : edge_cnt_ff + 9'h001;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         gen_lfsr_ff <= `TSM_PRBS_SEED;
         chk_lfsr_ff <= `TSM_PRBS_SEED;
         err_cnt_ff <= 16'h0000;
         dly0_ff <= 4'h0;
         dly1_ff <= 4'h0;
         tx_ff <= 8'h00;
         DOUT_O <= 8'h00;
         DOUT_OE <= 8'h00;
      end else begin
         if (!cfg_ff.prbs_gen_enable)
            gen_lfsr_ff <= `TSM_PRBS_SEED;
         else if (prbs_hit)
            gen_lfsr_ff <= lfsr_step(gen_lfsr_ff, gen_fb);
         if (!cfg_ff.prbs_check_enable) begin
            chk_lfsr_ff <= `TSM_PRBS_SEED;
            err_cnt_ff <= 16'h0000;
         end else if (prbs_hit) begin
            chk_lfsr_ff <= lfsr_step(chk_lfsr_ff, chk_in);
            if (chk_bad && err_cnt_ff != 16'hFFFF)
               err_cnt_ff <= err_cnt_ff + 16'h0001;
         end
         if (strobe[0])
            dly0_ff <= {dly0_ff[2:0], din_s2_ff[0]};
         if (strobe[1])
            dly1_ff <= {dly1_ff[2:0], din_s2_ff[1]};
         tx_ff <= nxt_tx;
         DOUT_O <= nxt_o;
         DOUT_OE <= nxt_oe;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         for (int c = 0; c < 16; c++)
            alarm_tmr_ff[c] <= 20'h00000;
         alarm_done_ff <= 16'h0000;
         ALARM_EVT <= 1'b0;
         ALARM_CH <= 4'h0;
      end else begin
         for (int c = 0; c < 16; c++) begin
            if (!alarm_on || b_zero[c]) begin
               alarm_tmr_ff[c] <= 20'h00000;
               alarm_done_ff[c] <= 1'b0;
            end else if (alarm_tmr_ff[c] != 20'(ALARM_CYC - 1)) begin
               alarm_tmr_ff[c] <= alarm_tmr_ff[c] + 20'h00001;
            end else begin
               alarm_done_ff[c] <= 1'b1;
            end
         end
         ALARM_EVT <= |fire;
         ALARM_CH <= fire_ch;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_open_drain_a;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_ff.drive_mode_a |=> (DOUT_O & 8'hCF) == 8'h00;
   endproperty
   a_open_drain_a: assert property (p_open_drain_a)
      else $error("open drain lines drove high");
   property p_open_drain_b;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_ff.drive_mode_b && !tx_ff[4] |=> !DOUT_O[4] && DOUT_OE[4];
   endproperty
   a_open_drain_b: assert property (p_open_drain_b)
      else $error("line 4 open drain zero not driven low");
   property p_gen_reset;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_ff.prbs_gen_enable |=> gen_lfsr_ff == `TSM_PRBS_SEED;
   endproperty
   a_gen_reset: assert property (p_gen_reset)
      else $error("generator not held in reset");
   property p_chk_reset;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !cfg_ff.prbs_check_enable |=> err_cnt_ff == 16'h0000;
   endproperty
   a_chk_reset: assert property (p_chk_reset)
      else $error("analyzer counted while disabled");
   property p_corrupt_once;
      @(posedge REF_CLK) disable iff (SYS_RST)
      corrupt_now && !sgc_set |=> !cfg_ff.prbs_gen_corrupt;
   endproperty
   a_corrupt_once: assert property (p_corrupt_once)
      else $error("corrupt bit did not self clear");
   property p_alarm_gate;
      @(posedge REF_CLK) disable iff (SYS_RST)
      ALARM_EVT |-> $past(alarm_on) && alarm_sts_ff[ALARM_CH];
   endproperty
   a_alarm_gate: assert property (p_alarm_gate)
      else $error("alarm without detection enabled");
   property p_alarm_time;
      @(posedge REF_CLK) disable iff (SYS_RST)
      |fire |-> alarm_tmr_ff[fire_ch] == 20'(ALARM_CYC - 1);
   endproperty
   a_alarm_time: assert property (p_alarm_time)
      else $error("alarm before full interval");
   property p_double_lost;
      @(posedge REF_CLK) disable iff (SYS_RST)
      dbl[0] |=> !DOUT_OE[1];
   endproperty
   a_double_lost: assert property (p_double_lost)
      else $error("ignored line 1 still driven");
   property p_half_rate;
      @(posedge REF_CLK) disable iff (SYS_RST)
      sw0_on |=> !DOUT_OE[2];
   endproperty
   a_half_rate: assert property (p_half_rate)
      else $error("line 2 driven in half rate mode");
endmodule : tsm_switch_cfg
`default_nettype wire

// ### common/tsm_consts.svh
// constants of the switching matrix configuration block
// assumes a 25 MHz system clock and 32-bit AXI4-Lite words
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH
// register indices; byte address is four times the index
`define TSM_IDX_CFG 8'h0C
`define TSM_IDX_CONN 8'h20
`define TSM_IDX_PRBS 8'h21
`define TSM_IDX_ALARM 8'h22
`define TSM_IDX_ERRS 8'h23
`define TSM_CFG_RST 16'h0000
// config field positions
`define TSM_POS_CORRUPT 5
// connection register fields
`define TSM_CONN_ENTRY_HI 10
`define TSM_CONN_ENTRY_LO 8
// prbs register fields: slot 5:0, line 8:6
`define TSM_PRBS_LINE_LO 6
`define TSM_PRBS_SEED 9'h1FF
// timing
`define TSM_CLK_KHZ 25000
`define TSM_ALARM_MS 30
`define TSM_ALARM_CYC (`TSM_ALARM_MS * `TSM_CLK_KHZ)
`define TSM_RESP_OK 2'h0
`define TSM_RESP_ERR 2'h2
`endif

// ### common/tsm_pkg.sv
// types of the switching matrix configuration block
// assumes tsm_consts.svh for every number
package tsm_pkg;
   typedef struct packed {
      logic half_rate_switch_b;
      logic half_rate_switch_a;
      logic rate_select_hi;
      logic rate_select_lo;
      logic double_rate_mux6;
      logic double_rate_mux4;
      logic double_rate_mux2;
      logic double_rate_mux0;
      logic alarm_detect_enable;
      logic message_mode;
      logic prbs_gen_corrupt;
      logic prbs_check_enable;
      logic prbs_gen_enable;
      logic drive_mode_b;
      logic drive_mode_a;
      logic min_delay_plus;
   } tsm_cfg_s;
   typedef struct packed {
      logic [2:0] line;
      logic [5:0] slot;
   } tsm_prbs_s;
endpackage : tsm_pkg

// ### dv/tsm_link_model.sv
// line side model: bit clock, frame sync and serial input lines
// assumes the design samples all of it on its own clock
`timescale 1ns/1ps
`default_nettype none
module tsm_link_model (
   input wire logic all_ones,
   output logic MUX_BIT_CLOCK,
   output logic FRAME_SYNC,
   output logic [7:0] DIN
);
   // ----
   // link timing
   // ----
   int edges;
   // free running: a line clock does not pause between frames
   initial begin
      MUX_BIT_CLOCK = 1'b0;
      FRAME_SYNC = 1'b0;
      DIN = 8'h00;
      edges = 0;
      #7;
      forever begin
         #160 MUX_BIT_CLOCK = ~MUX_BIT_CLOCK;
         if (!MUX_BIT_CLOCK) begin
            edges = (edges + 1) % 512;
            FRAME_SYNC = (edges == 0);
            // data moves on falling edges, away from sampling
            if (edges % 2 == 0) begin
               DIN = all_ones ? 8'hFF : ~DIN ^ 8'(edges);
            end
         end
      end
   end
endmodule : tsm_link_model
`default_nettype wire

// ### dv/tdm_switch_matrix_config_tb.sv
// self-checking bench of the switching matrix configuration block
// assumes tsm_link_model drives the line side
`timescale 1ns/1ps
`default_nettype none
`include "tsm_consts.svh"
module tdm_switch_matrix_config_tb
   import tsm_pkg::*;
;
   typedef struct packed {
      logic [15:0] cfg;
      logic [7:0] val;
      logic [7:0] oe;
      logic [7:0] o;
      logic hd;
   } tsm_row_s;
   localparam logic [31:0] A_CFG = {22'h0, `TSM_IDX_CFG, 2'h0};
   localparam logic [31:0] A_CONN = {22'h0, `TSM_IDX_CONN, 2'h0};
   localparam logic [31:0] A_PRBS = {22'h0, `TSM_IDX_PRBS, 2'h0};
   localparam logic [31:0] A_ALM = {22'h0, `TSM_IDX_ALARM, 2'h0};
   localparam logic [31:0] A_ERR = {22'h0, `TSM_IDX_ERRS, 2'h0};
   localparam logic [31:0] A_BAD = 32'h00000090;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, all_ones = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, mbc, fsync;
   logic [1:0] bresp, rresp, r;
   logic [7:0] din, dout_o, dout_oe;
   logic alarm_evt, hdlc;
   logic [3:0] alarm_ch, first_ch;
   int fail_count = 0;
   int samples_checked = 0;
   int evts = 0;
   int i, e, n;
   tsm_row_s rows [8] = '{
      '{16'h0046, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{16'h0040, 8'hFF, 8'h00, 8'h00, 1'b0},
      '{16'h0040, 8'h00, 8'hFF, 8'h00, 1'b0},
      '{16'h0044, 8'hFF, 8'h30, 8'h30, 1'b0},
      '{16'h0F46, 8'hFF, 8'h55, 8'hFF, 1'b1},
      '{16'h1F46, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{16'hC046, 8'hFF, 8'hF3, 8'hFF, 1'b0},
      '{16'h1146, 8'hFF, 8'hFF, 8'hFF, 1'b0}};

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (alarm_evt === 1'b1) begin
         if (evts == 0) first_ch = alarm_ch;
         evts++;
      end
   end

   tsm_link_model tsm_link_model_inst (.all_ones(all_ones),
      .MUX_BIT_CLOCK(mbc), .FRAME_SYNC(fsync), .DIN(din));
   // short alarm count keeps the run brief
   tsm_switch_cfg #(.ALARM_CYC(50)) tsm_switch_cfg_inst (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .MUX_BIT_CLOCK(mbc),
      .FRAME_SYNC(fsync), .DIN(din), .DOUT_O(dout_o),
      .DOUT_OE(dout_oe), .ALARM_EVT(alarm_evt),
      .ALARM_CH(alarm_ch), .HDLC_DIRECT(hdlc));

   // ----
   // tasks
   // ----
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %0h expected %0h",
            $time, seen, exp);
      end
   endtask : chk

   task end_of_test;
      $display("comparisons %0d, mismatches %0d", samples_checked,
         fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : cyc

   task wr(input logic [31:0] a, input logic [31:0] v,
      input logic [3:0] s);
      int k;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (k == 100) begin
         fail_count++;
         end_of_test();
      end
   endtask : wr

   task rd(input logic [31:0] a);
      int k;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (k == 100) begin
         fail_count++;
         end_of_test();
      end
   endtask : rd

   // ----
   // sequence
   // ----
   initial begin
      cyc(20);
      sys_rst <= 1'b0;
      cyc(2);
      chk({24'h0, dout_oe}, 32'h000000FF);
      rd(A_CFG);
      chk(d, {16'h0, `TSM_CFG_RST});
      rd(A_ALM);
      chk(d, 32'h0);
      rd(A_ERR);
      chk(d, 32'h0);
      $display("reset test done");
      // message mode with all entries equal: every line static
      for (i = 0; i < 8; i++) begin
         wr(A_CFG, {16'h0, rows[i].cfg}, 4'hF);
         for (e = 0; e < 8; e++) wr(A_CONN, {21'h0, 3'(e), rows[i].val}, 4'hF);
         cyc(100);
         rd(A_CFG);
         chk(d, {16'h0, rows[i].cfg});
         chk({24'h0, dout_oe}, {24'h0, rows[i].oe});
         chk({24'h0, dout_o}, {24'h0, rows[i].o});
         chk({31'h0, hdlc}, {31'h0, rows[i].hd});
         $display("row %0d done", i);
      end
      wr(A_CFG, 32'h0, 4'hF);
      wr(A_CFG, 32'h000055AA, 4'h2);
      rd(A_CFG);
      chk(d, 32'h00005500);
      rd(A_BAD);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, `TSM_RESP_ERR});
      wr(A_BAD, 32'hFFFF, 4'hF);
      chk({30'h0, r}, {30'h0, `TSM_RESP_ERR});
      $display("bus test done");
      wr(A_PRBS, 32'h0, 4'hF);
      wr(A_CFG, 32'h002E, 4'hF);
      for (n = 0; n < 100; n++) begin
         cyc(100);
         rd(A_CFG);
         if (d[5] === 1'b0) break;
      end
      chk(d, 32'h000E);
      $display("corrupt test done");
      all_ones = 1'b1;
      wr(A_CFG, 32'h0010, 4'hF);
      cyc(9000);
      rd(A_ERR);
      chk({31'h0, d != 32'h0}, 32'h1);
      $display("analyzer test done");
      wr(A_CFG, 32'h0, 4'hF);
      evts = 0;
      cyc(4200);
      chk(evts, 0);
      wr(A_CFG, 32'h0080, 4'hF);
      for (n = 0; n < 10000 && evts < 1; n++) @(posedge ref_clk);
      cyc(200);
      chk(evts, 1);
      chk({28'h0, first_ch}, 32'h0);
      rd(A_ALM);
      chk(d, 32'h0000FFFF);
      wr(A_ALM, 32'h0000FFFF, 4'hF);
      rd(A_ALM);
      chk(d, 32'h0);
      $display("alarm test done");
      end_of_test();
   end
endmodule : tdm_switch_matrix_config_tb
`default_nettype wire
